/* File: dv/pds_adc_src.sv */
// Sensor sample source: random samples with random gaps; frame starts follow fs_req_in.
// Assumes the bench seeds the generator and drives the controls.
`timescale 1ns/10ps
module pds_adc_src (
	// Clock, reset and controls.
	input  wire logic        clk_in,
	input  wire logic        rst_b_in,
	input  wire logic        run_in,
	input  wire logic        fs_req_in,
	input  wire logic [11:0] mask_in,
	// Sample stream.
	output logic             fs_out,
	output logic             vld_out,
	output logic [11:0]      smp_out
);
	logic go;
	// Idle data is inverted each cycle so stale samples never look valid.
	always @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			fs_out <= 1'b0;
			vld_out <= 1'b0;
			smp_out <= 12'h000;
		end else begin
			go = run_in && !fs_req_in && ($urandom % 4 != 0);
			fs_out <= fs_req_in;
			vld_out <= go;
			smp_out <= go ? (12'($urandom) & mask_in) : ~smp_out;
		end
	end
endmodule // pds_adc_src

/* File: dv/pds_checker.sv */
// Assertions on the ports of the bit-window shift stage.
// Assumes an APB master that keeps setup and access phases.
`timescale 1ns/10ps
`include "pds_regs.vh"
module pds_checker #(
	parameter ADC_W = 12
) (
	// Clock and reset.
	input wire logic             CLK_SYS_IN,
	input wire logic             RST_B_IN,
	// Register bus.
	input wire logic             PSEL_IN,
	input wire logic             PENABLE_IN,
	input wire logic             PWRITE_IN,
	input wire logic [11:0]      PADDR_IN,
	input wire logic [31:0]      PWDATA_IN,
	input wire logic             PSLVERR_OUT,
	// Streams and gain.
	input wire logic             FRAME_START_IN,
	input wire logic             SAMPLE_VALID_IN,
	input wire logic [ADC_W-1:0] SAMPLE_IN,
	input wire logic             PIXEL_VALID_OUT,
	input wire logic [ADC_W-1:0] PIXEL_OUT,
	input wire logic             PIXEL_FMT8_OUT,
	input wire logic [15:0]      GAIN_OUT
);
	// ------
	// Shadow of configuration and expected pixel
	// ------
	logic [2:0]  sh_q, sa_q;
	logic        f8_q, fa_q, rel_q, sat_q, ef_q;
	logic [11:0] ex_q;
	wire  [23:0] up = {12'h000, SAMPLE_IN} << sa_q;
	wire         wr = PSEL_IN & PENABLE_IN & PWRITE_IN;
	// Shift settings latch only at frame start, so a frame never mixes.
	always @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			{sh_q, sa_q, f8_q, fa_q, rel_q, sat_q, ef_q} <= 11'h000;
			ex_q <= 12'h000;
		end else begin
			if (wr && PADDR_IN == `PDS_CTRL_OFF) begin
				sh_q <= (PWDATA_IN[2:0] > `PDS_SHIFT_MAX) ?
					`PDS_SHIFT_MAX : PWDATA_IN[2:0];
				f8_q <= PWDATA_IN[4];
			end
			if (wr && PADDR_IN == `PDS_LIMIT_OFF)
				rel_q <= PWDATA_IN[0] & (PWDATA_IN[5:4] == `PDS_SEL_GAIN);
			if (FRAME_START_IN) begin
				sa_q <= sh_q;
				fa_q <= f8_q;
			end
			if (SAMPLE_VALID_IN) begin
				sat_q <= |up[23:12];
				ef_q <= fa_q;
				ex_q <= fa_q ? {4'h0, up[11:4]} : up[11:0];
			end
		end
	end
	default clocking @(posedge CLK_SYS_IN); endclocking
	default disable iff (!RST_B_IN);
	a_pixel_follows: assert property (SAMPLE_VALID_IN |=> PIXEL_VALID_OUT)
		else $error("pixel missing after sample");
	a_no_extra: assert property (!SAMPLE_VALID_IN |=> !PIXEL_VALID_OUT)
		else $error("pixel without sample");
	a_pass_through: assert property (SAMPLE_VALID_IN && sa_q == 3'h0 && !fa_q
		|=> PIXEL_OUT == $past(SAMPLE_IN)) else $error("unshifted pixel wrong");
	a_window_twelve: assert property (PIXEL_VALID_OUT && !sat_q && !ef_q
		|-> PIXEL_OUT == ex_q) else $error("12-bit window wrong");
	a_window_eight: assert property (PIXEL_VALID_OUT && !sat_q && ef_q
		|-> PIXEL_OUT == ex_q) else $error("8-bit window wrong");
	a_saturate_all: assert property (PIXEL_VALID_OUT && sat_q
		|-> PIXEL_OUT == (ef_q ? 12'h0ff : 12'hfff)) else $error("no saturation");
	a_frame_format: assert property (PIXEL_VALID_OUT |-> PIXEL_FMT8_OUT == ef_q)
		else $error("format flag wrong");
	a_gain_floor: assert property (!rel_q [*3] |-> !GAIN_OUT[15])
		else $error("negative gain without relax");
	a_gain_ceiling: assert property (!GAIN_OUT[15] |-> GAIN_OUT <= 16'h00ff)
		else $error("gain above ceiling");
	a_unmapped_err: assert property (PSEL_IN && PENABLE_IN && PADDR_IN > 12'h00c
		|-> PSLVERR_OUT) else $error("unmapped access not refused");
endmodule // pds_checker
bind pds_top pds_checker #(.ADC_W(ADC_W)) u_chk (.CLK_SYS_IN(CLK_SYS_IN),
	.RST_B_IN(RST_B_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
	.PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN),
	.PSLVERR_OUT(PSLVERR_OUT), .FRAME_START_IN(FRAME_START_IN),
	.SAMPLE_VALID_IN(SAMPLE_VALID_IN), .SAMPLE_IN(SAMPLE_IN),
	.PIXEL_VALID_OUT(PIXEL_VALID_OUT), .PIXEL_OUT(PIXEL_OUT),
	.PIXEL_FMT8_OUT(PIXEL_FMT8_OUT), .GAIN_OUT(GAIN_OUT));

/* File: dv/testbench.sv */
// Self-checking bench: APB tasks, sample source and a queue model.
// Assumes the checker is bound to the top module.
`timescale 1ns/10ps
`include "pds_regs.vh"
module testbench;
	logic        clk = 0, rst_b = 0, psel = 0, pen = 0, pwr = 0;
	logic        run = 0, fsr = 0, e;
	logic [11:0] pa = 0, msk = 0;
	logic [31:0] pwd = 0, r;
	logic [31:0] lim [4] = '{32'h0, 32'h21, 32'h01, 32'h11};
	wire         prdy, perr, fs, vld, pv, pf8;
	wire  [31:0] prd;
	wire  [11:0] smp, px;
	wire  [15:0] gain;
	logic [12:0] q [$];
	int          n_fail = 0, n_checks = 0, csh, cf8, ash = 0, af8 = 0;
	initial forever #2 clk = ~clk;
	pds_top uut (.CLK_SYS_IN(clk), .RST_B_IN(rst_b), .PSEL_IN(psel),
		.PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(pa), .PWDATA_IN(pwd),
		.PREADY_OUT(prdy), .PSLVERR_OUT(perr), .PRDATA_OUT(prd),
		.FRAME_START_IN(fs), .SAMPLE_VALID_IN(vld), .SAMPLE_IN(smp),
		.PIXEL_VALID_OUT(pv), .PIXEL_OUT(px), .PIXEL_FMT8_OUT(pf8),
		.GAIN_OUT(gain));
	pds_adc_src src (.clk_in(clk), .rst_b_in(rst_b), .run_in(run),
		.fs_req_in(fsr), .mask_in(msk), .fs_out(fs), .vld_out(vld),
		.smp_out(smp));
	// ------
	// Tasks and model
	// ------
	task finish_test;
		if (n_fail == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] x);
		n_checks++;
		if (g !== x) begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask
	// One edge passes first, so a release never meets a new request.
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1;
		pwr <= w;
		pa <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (prdy !== 1'b1 && n < 64);
		r = prd;
		e = perr;
		psel <= 0;
		pen <= 0;
		if (n >= 64) begin
			n_fail++;
			finish_test;
		end
	endtask
	// Window taken from the sample shifted up; overflow saturates.
	function logic [12:0] mdl(int s, int h, int f);
		int w;
		w = s << h;
		if (w > 4095)
			w = f ? 255 : 4095;
		else if (f)
			w = w >> 4;
		return {f[0], w[11:0]};
	endfunction
	// Pixels pair with samples in order; config moves only at frame start.
	always @(posedge clk) begin
		if (rst_b && pv)
			chk({pf8, px}, q.size() ? q.pop_front() : 32'hx);
		if (rst_b && vld)
			q.push_back(mdl(smp, ash, af8));
		if (fs) begin
			ash = csh;
			af8 = cf8;
		end
	end
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		finish_test;
	end
	initial begin
		void'($urandom(42));
		repeat (2) @(posedge clk);
		rst_b <= 1;
		apb(0, `PDS_CTRL_OFF, 0);
		chk(r, `PDS_CTRL_RST);
		apb(1, 12'h010, 32'hffff);
		apb(0, 12'h010, 0);
		chk({e, r}, 33'h1_0000_0000);
		run <= 1;
		for (int k = 0; k < 12; k++) begin
			csh = (k % 6 > 4) ? 4 : k % 6;
			cf8 = k / 6;
			apb(1, `PDS_CTRL_OFF, ((k / 6) << 4) | (k % 6));
			msk <= 12'hfff;
			repeat (20) @(posedge clk);
			fsr <= 1;
			@(posedge clk);
			fsr <= 0;
			msk <= 12'hfff >> csh;
			repeat (30) @(posedge clk);
			apb(0, `PDS_STATUS_OFF, 0);
			chk(r[4:0], (cf8 << 4) | csh);
		end
		run <= 0;
		for (int i = 0; i < 4; i++) begin
			apb(1, `PDS_LIMIT_OFF, lim[i]);
			apb(1, `PDS_GAIN_OFF, 32'hfff0);
			apb(0, `PDS_GAIN_OFF, 0);
			chk(gain, (i == 3) ? 16'hfff0 : 16'h0);
		end
		apb(1, `PDS_GAIN_OFF, 32'h8000);
		apb(0, `PDS_GAIN_OFF, 0);
		chk(gain, 16'h8000);
		apb(1, `PDS_LIMIT_OFF, 0);
		apb(1, `PDS_GAIN_OFF, 32'h1234);
		apb(0, `PDS_GAIN_OFF, 0);
		chk(gain, 16'h00ff);
		chk(q.size(), 0);
		finish_test;
	end
endmodule // testbench

/* File: hdl/pds_gain_limit.v */
// Gain parameter store whose lower bound depends on limit removal.
// Assumes writes arrive as a one-cycle strobe with signed data.
`timescale 1ns/10ps
`include "pds_regs.vh"

module pds_gain_limit (
	// Clock and reset.
	input  wire        clk_in,
	input  wire        rst_b_in,
	// Write request and limit control.
	input  wire        wr_in,
	input  wire [15:0] wdata_in,
	input  wire        relax_in,
	// Stored gain.
	output reg  [15:0] gain_out
);

	// Clamp to the register floor only when not relaxed; the ceiling never moves.
	function [15:0] clamp;
		input [15:0] v;
		input        relax;
		begin
			if ($signed(v) > $signed(`PDS_GAIN_MAX)) begin
				clamp = `PDS_GAIN_MAX;
			end else if (!relax && $signed(v) < $signed(`PDS_GAIN_MIN_REG)) begin
				clamp = `PDS_GAIN_MIN_REG;
			end else begin
				clamp = v;
			end
		end
	endfunction

	// Written values clamp at write time; restoring limits re-clamps.
	always @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			gain_out <= `PDS_GAIN_RST;
		end else if (wr_in) begin
			gain_out <= clamp(wdata_in, relax_in);
		end else begin
			gain_out <= clamp(gain_out, relax_in);
		end
	end

endmodule // pds_gain_limit

/* File: hdl/pds_regs.vh */
// Register map, field positions, reset values and limits of the pixel
// bit-window shift stage. Assumes inclusion by every design file.
`ifndef PDS_REGS_VH
`define PDS_REGS_VH

// -----------------------------------------------------------------------
// Register byte offsets
// -----------------------------------------------------------------------
`define PDS_CTRL_OFF      12'h000
`define PDS_LIMIT_OFF     12'h004
`define PDS_GAIN_OFF      12'h008
`define PDS_STATUS_OFF    12'h00c

// -----------------------------------------------------------------------
// Field positions and widths
// -----------------------------------------------------------------------
`define PDS_CTRL_SHIFT_LSB   0
`define PDS_CTRL_SHIFT_W     3
`define PDS_CTRL_FMT8_BIT    4
`define PDS_LIMIT_FLAG_BIT   0
`define PDS_LIMIT_SEL_LSB    4
`define PDS_LIMIT_SEL_W      2
`define PDS_SEL_GAIN         2'h1
`define PDS_GAIN_W           16

// -----------------------------------------------------------------------
// Reset values and bounds
// -----------------------------------------------------------------------
`define PDS_CTRL_RST      32'h0000_0000
`define PDS_LIMIT_RST     32'h0000_0000
`define PDS_GAIN_RST      16'h0000
`define PDS_SHIFT_MAX     3'h4
`define PDS_GAIN_MAX      16'sh00ff
`define PDS_GAIN_MIN_REG  16'sh0000
`define PDS_GAIN_MIN_EXT  16'sh8000

`endif

/* File: hdl/pds_top.v */
// Pixel bit-window shift stage with APB registers and gain limit control.
// Assumes samples and frame start synchronous to CLK_SYS_IN.
//
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/10ps
`include "pds_regs.vh"

module pds_top #(
	parameter ADC_W = 12
) (
	// Clock and reset.
	input  wire             CLK_SYS_IN,
	input  wire             RST_B_IN,
	// APB slave.
	input  wire             PSEL_IN,
	input  wire             PENABLE_IN,
	input  wire             PWRITE_IN,
	input  wire [11:0]      PADDR_IN,
	input  wire [31:0]      PWDATA_IN,
	output wire             PREADY_OUT,
	output wire             PSLVERR_OUT,
	output reg  [31:0]      PRDATA_OUT,
	// Sample stream.
	input  wire             FRAME_START_IN,
	input  wire             SAMPLE_VALID_IN,
	input  wire [ADC_W-1:0] SAMPLE_IN,
	// Pixel stream.
	output reg              PIXEL_VALID_OUT,
	output reg  [ADC_W-1:0] PIXEL_OUT,
	output reg              PIXEL_FMT8_OUT,
	// Gain towards the amplifier.
	output wire [15:0]      GAIN_OUT
);

	// -------------------------------------------------------------------
	// Register state
	// -------------------------------------------------------------------
	reg  [2:0]       shift_sw_q;
	reg              fmt8_sw_q;
	reg  [2:0]       shift_act_q;
	reg              fmt8_act_q;
	reg  [1:0]       limit_target_select_q;
	reg              limit_removal_flag_q;
	wire             wr_en;
	wire             rd_en;
	wire             addr_ok;
	wire             relax;
	wire [ADC_W-1:0] pixel_d;
	reg  [31:0]      rdata_d;

	// Single-cycle access phase keeps the slave simple.
	assign PREADY_OUT  = 1'b1;
	assign addr_ok     = (PADDR_IN == `PDS_CTRL_OFF) ||
	                     (PADDR_IN == `PDS_LIMIT_OFF) ||
	                     (PADDR_IN == `PDS_GAIN_OFF) ||
	                     (PADDR_IN == `PDS_STATUS_OFF);
	assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & ~addr_ok;
	assign wr_en       = PSEL_IN & PENABLE_IN & PWRITE_IN;
	assign rd_en       = PSEL_IN & PENABLE_IN & ~PWRITE_IN;

	// Removal applies only when the selector names the gain.
	assign relax = limit_removal_flag_q &&
	               (limit_target_select_q == `PDS_SEL_GAIN);

	// -------------------------------------------------------------------
	// Software-written registers
	// -------------------------------------------------------------------

	// Shift settings above four are held at four, the largest shift.
	always @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			shift_sw_q            <= 3'h0;
			fmt8_sw_q             <= 1'b0;
			limit_target_select_q <= 2'h0;
			limit_removal_flag_q  <= 1'b0;
		end else if (wr_en) begin
			if (PADDR_IN == `PDS_CTRL_OFF) begin
				fmt8_sw_q <= PWDATA_IN[`PDS_CTRL_FMT8_BIT];
				if (PWDATA_IN[2:0] > `PDS_SHIFT_MAX) begin
					shift_sw_q <= `PDS_SHIFT_MAX;
				end else begin
					shift_sw_q <= PWDATA_IN[2:0];
				end
			end
			if (PADDR_IN == `PDS_LIMIT_OFF) begin
				limit_removal_flag_q  <= PWDATA_IN[`PDS_LIMIT_FLAG_BIT];
				limit_target_select_q <= PWDATA_IN[5:4];
			end
		end
	end

	// -------------------------------------------------------------------
	// Frame-boundary latch of the active configuration
	// -------------------------------------------------------------------

	// Mid-frame changes wait so one frame never mixes two windows.
	always @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			shift_act_q <= 3'h0;
			fmt8_act_q  <= 1'b0;
		end else if (FRAME_START_IN) begin
			shift_act_q <= shift_sw_q;
			fmt8_act_q  <= fmt8_sw_q;
		end
	end

	// -------------------------------------------------------------------
	// Datapath
	// -------------------------------------------------------------------

	// Unsaturated eight-bit cases take the top byte of the shifted word; saturated ones give 8'hff.
	pds_window #(
		.ADC_W     (ADC_W)
	) u_window (
		.sample_in (SAMPLE_IN),
		.shift_in  (shift_act_q),
		.fmt8_in   (fmt8_act_q),
		.pixel_out (pixel_d)
	);

	// One register stage; the format flag travels with each pixel.
	always @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			PIXEL_VALID_OUT <= 1'b0;
			PIXEL_OUT       <= {ADC_W{1'b0}};
			PIXEL_FMT8_OUT  <= 1'b0;
		end else begin
			PIXEL_VALID_OUT <= SAMPLE_VALID_IN;
			if (SAMPLE_VALID_IN) begin
				PIXEL_OUT      <= pixel_d;
				PIXEL_FMT8_OUT <= fmt8_act_q;
			end
		end
	end

	// -------------------------------------------------------------------
	// Gain store
	// -------------------------------------------------------------------
	pds_gain_limit u_gain (
		.clk_in   (CLK_SYS_IN),
		.rst_b_in (RST_B_IN),
		.wr_in    (wr_en && (PADDR_IN == `PDS_GAIN_OFF)),
		.wdata_in (PWDATA_IN[15:0]),
		.relax_in (relax),
		.gain_out (GAIN_OUT)
	);

	// -------------------------------------------------------------------
	// Read path
	// -------------------------------------------------------------------

	// Status shows the configuration actually applied this frame.
	always @* begin
		rdata_d = 32'h0000_0000;
		case (PADDR_IN)
			`PDS_CTRL_OFF: begin
				rdata_d[2:0] = shift_sw_q;
				rdata_d[4]   = fmt8_sw_q;
			end
			`PDS_LIMIT_OFF: begin
				rdata_d[0]   = limit_removal_flag_q;
				rdata_d[5:4] = limit_target_select_q;
			end
			`PDS_GAIN_OFF: begin
				rdata_d[15:0] = GAIN_OUT;
			end
			`PDS_STATUS_OFF: begin
				rdata_d[2:0] = shift_act_q;
				rdata_d[4]   = fmt8_act_q;
				rdata_d[8]   = relax;
			end
			default: begin
				rdata_d = 32'h0000_0000;
			end
		endcase
	end

	// Read data is registered during the setup phase, ready at access.
	always @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			PRDATA_OUT <= 32'h0000_0000;
		end else if (PSEL_IN && !PENABLE_IN && !PWRITE_IN) begin
			PRDATA_OUT <= rdata_d;
		end
	end

endmodule // pds_top

/* File: hdl/pds_window.v */
// Combinational bit-window selector with saturation for one sample.
// Assumes a 12-bit sample and a shift already limited to 0..4.
`timescale 1ns/10ps
`include "pds_regs.vh"

module pds_window #(
	parameter ADC_W = 12
) (
	// Sample and configuration.
	input  wire [ADC_W-1:0] sample_in,
	input  wire [2:0]       shift_in,
	input  wire             fmt8_in,
	// Selected pixel, low bits hold the 8-bit form.
	output reg  [ADC_W-1:0] pixel_out
);

	reg [ADC_W-1:0] shifted;
	reg             over;
	reg [ADC_W-1:0] upper_mask;

	// Shift left, then test the bits pushed out for saturation.
	always @* begin
		shifted    = sample_in << shift_in;
		upper_mask = ~({ADC_W{1'b1}} >> shift_in);
		over       = |(sample_in & upper_mask);
		if (over) begin
			pixel_out = {ADC_W{1'b1}};
		end else if (fmt8_in) begin
			// The 8-bit view is the top byte of the shifted word.
			pixel_out = {4'h0, shifted[ADC_W-1:ADC_W-8]};
		end else begin
			pixel_out = shifted;
		end
		if (over && fmt8_in) begin
			pixel_out = {4'h0, 8'hff};
		end
	end

endmodule // pds_window
